//--- pkg/pwi_regs.svh
/*
 * Register offsets, field positions and reset values of the port wakeup
 * interrupt block. Assumes byte addresses on a 32-bit AHB-Lite bus, one
 * aligned word per register.
 */
`ifndef PWI_REGS_SVH
`define PWI_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PWI_OFS_WAKE_EN 8'h00
`define PWI_OFS_EDGE_SEL 8'h04
`define PWI_OFS_PENDING 8'h08
`define PWI_OFS_CTRL 8'h0c
`define PWI_OFS_STATUS 8'h10
`define PWI_OFS_INT_STAT 8'h14
`define PWI_OFS_INT_MASK 8'h18
`define PWI_OFS_SLEEP_LEN 8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define PWI_CTRL_PORT_IRQ_EN 0
`define PWI_CTRL_GIE 1
`define PWI_CTRL_STOP_REQ 2
`define PWI_CTRL_SLEEP_REQ 3
`define PWI_STAT_STOPPED 0
`define PWI_STAT_SLEEPING 1
`define PWI_INT_WAKE 0
`define PWI_INT_REFUSED 1
`define PWI_INT_TIMEOUT 2

// ****************************************************************
// Reset values
// ****************************************************************
`define PWI_RST_BYTE 8'h00
`define PWI_RST_INT 3'h0
`define PWI_RST_SLEEP_LEN 16'h0000
`define PWI_RST_WORD 32'h00000000

`endif

//--- pkg/pwi_pkg.sv
/*
 * Types shared by the port wakeup interrupt block.
 * Assumes the register header is included where offsets are needed.
 */
package pwi_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Low-power state of the core as seen by the wakeup logic.
  typedef enum logic [1:0] {
    LPM_RUN,
    LPM_STOP,
    LPM_SLEEP
  } pwi_lpm_e;

  // One bit for each port pin.
  typedef logic [7:0] pwi_port_t;

endpackage

//--- verilog/pwi_port_wakeup.sv
/*
 * Multi-input wakeup and shared edge interrupt for an eight-pin port,
 * with an AHB-Lite register slave and a small low-power controller.
 * Assumes one AHB master, word-sized single transfers, async port pins.
 */
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "pwi_regs.svh"

module pwi_port_wakeup (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Port pins
  input wire logic [7:0] portPin,
  // Core side
  output logic coreStopped,
  output logic coreSleeping,
  output logic wakeResume,
  output logic wakeService,
  output logic portIrqReq,
  // Block interrupt
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pwi_pkg::pwi_port_t wakeEnableMask_r, wakeEdgeSelect_r, wakePending_r;
  pwi_pkg::pwi_port_t syncA_r, syncB_r, syncC_r, stable_r;
  pwi_pkg::pwi_port_t edgeHit, wakeActive, pendClr;
  logic [2:0] intStat_r, intMask_r, intSet, intClr;
  logic [15:0] sleepLen_r, sleepCnt_r;
  logic [31:0] hrdata_r, rdMux;
  logic [7:0] wrAddr_r;
  logic portIrqGlobalEnable_r, globalIrqEnable_r, wrValid_r, addrAccept;
  logic wrEn, stopReq, sleepReq, anyActive, wakeResume_r, wakeService_r;
  pwi_pkg::pwi_lpm_e lpmState_r, lpmState_nxt;

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  // Three stages; a new level counts only once the second and third
  // agree, which filters a single-cycle glitch at the cost of latency.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_r <= `PWI_RST_BYTE;
      syncB_r <= `PWI_RST_BYTE;
      syncC_r <= `PWI_RST_BYTE;
    end else begin
      syncA_r <= portPin;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end
  // The accepted level follows the settled synchronised value.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stable_r <= `PWI_RST_BYTE;
    end else begin
      stable_r <= (syncB_r ~^ syncC_r) & syncC_r |
                  (syncB_r ^ syncC_r) & stable_r;
    end
  end

  // A hit is a settled change in the direction the edge bit selects.
  // Stable resets low, so a pin that floats high after reset can raise a
  // rising hit; software must clear pending before enabling.
  always_comb begin
    edgeHit = (syncB_r ~^ syncC_r) & (syncC_r ^ stable_r) &
              (syncC_r ^ wakeEdgeSelect_r);
  end

  // ****************************************************************
  // Wakeup condition and shared request
  // ****************************************************************
  // Only enabled pins take part in wakeup and interrupt.
  always_comb begin
    wakeActive = wakeEnableMask_r & wakePending_r;
    anyActive = |wakeActive;
    portIrqReq = portIrqGlobalEnable_r & globalIrqEnable_r &
                 anyActive;
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states; every answer is OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  // Address phase decode. Only NONSEQ and SEQ transfers count.
  always_comb begin
    addrAccept = hsel & hready & htrans[1];
  end
  // Write address is held for the data phase.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrValid_r <= 1'b0;
      wrAddr_r <= `PWI_RST_BYTE;
    end else if (hready) begin
      wrValid_r <= addrAccept & hwrite;
      wrAddr_r <= haddr[7:0];
    end
  end

  // Read mux; unmapped offsets read zero. Reads are sampled in the
  // address phase, so a read right behind a write sees the old value.
  always_comb begin
    rdMux = `PWI_RST_WORD;
    if (haddr[31:8] == 24'h000000) begin
      unique case (haddr[7:0])
        `PWI_OFS_WAKE_EN: rdMux[7:0] = wakeEnableMask_r;
        `PWI_OFS_EDGE_SEL: rdMux[7:0] = wakeEdgeSelect_r;
        `PWI_OFS_PENDING: rdMux[7:0] = wakePending_r;
        `PWI_OFS_CTRL: begin
          rdMux[`PWI_CTRL_PORT_IRQ_EN] = portIrqGlobalEnable_r;
          rdMux[`PWI_CTRL_GIE] = globalIrqEnable_r;
        end
        `PWI_OFS_STATUS: begin
          rdMux[`PWI_STAT_STOPPED] = lpmState_r == pwi_pkg::LPM_STOP;
          rdMux[`PWI_STAT_SLEEPING] = lpmState_r == pwi_pkg::LPM_SLEEP;
          rdMux[15:8] = wakeActive;
        end
        `PWI_OFS_INT_STAT: rdMux[2:0] = intStat_r;
        `PWI_OFS_INT_MASK: rdMux[2:0] = intMask_r;
        `PWI_OFS_SLEEP_LEN: rdMux[15:0] = sleepLen_r;
        default: rdMux = `PWI_RST_WORD;
      endcase
    end
  end
  // Read data register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_r <= `PWI_RST_WORD;
    end else if (addrAccept & ~hwrite) begin
      hrdata_r <= rdMux;
    end
  end
  // Data phase write strobes.
  always_comb begin
    wrEn = wrValid_r;
    pendClr = (wrEn && wrAddr_r == `PWI_OFS_PENDING) ?
              hwdata[7:0] : `PWI_RST_BYTE;
    intClr = (wrEn && wrAddr_r == `PWI_OFS_INT_STAT) ?
             hwdata[2:0] : `PWI_RST_INT;
    stopReq = wrEn && wrAddr_r == `PWI_OFS_CTRL &&
              hwdata[`PWI_CTRL_STOP_REQ];
    sleepReq = wrEn && wrAddr_r == `PWI_OFS_CTRL &&
               hwdata[`PWI_CTRL_SLEEP_REQ] && !hwdata[`PWI_CTRL_STOP_REQ];
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Enable and edge registers are plain read/write bytes.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeEnableMask_r <= `PWI_RST_BYTE;
      wakeEdgeSelect_r <= `PWI_RST_BYTE;
    end else if (wrEn) begin
      if (wrAddr_r == `PWI_OFS_WAKE_EN) begin
        wakeEnableMask_r <= hwdata[7:0];
      end
      if (wrAddr_r == `PWI_OFS_EDGE_SEL) begin
        wakeEdgeSelect_r <= hwdata[7:0];
      end
    end
  end

  // Pending bits: a new edge wins over a clear in the same cycle, and
  // nothing but software or reset ever clears a bit.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakePending_r <= `PWI_RST_BYTE;
    end else begin
      wakePending_r <= (wakePending_r & ~pendClr) | edgeHit;
    end
  end
  // Port and global interrupt enables.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portIrqGlobalEnable_r <= 1'b0;
      globalIrqEnable_r <= 1'b0;
    end else if (wrEn && wrAddr_r == `PWI_OFS_CTRL) begin
      portIrqGlobalEnable_r <= hwdata[`PWI_CTRL_PORT_IRQ_EN];
      globalIrqEnable_r <= hwdata[`PWI_CTRL_GIE];
    end
  end
  // Interrupt mask and sleep length.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intMask_r <= `PWI_RST_INT;
      sleepLen_r <= `PWI_RST_SLEEP_LEN;
    end else if (wrEn) begin
      if (wrAddr_r == `PWI_OFS_INT_MASK) begin
        intMask_r <= hwdata[2:0];
      end
      if (wrAddr_r == `PWI_OFS_SLEEP_LEN) begin
        sleepLen_r <= hwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // Low-power controller
  // ****************************************************************
  // Stop is refused while an enabled pin is pending, otherwise the core
  // would sleep past a wakeup it can never see again.
  always_comb begin
    lpmState_nxt = lpmState_r;
    unique case (lpmState_r)
      pwi_pkg::LPM_RUN: begin
        if (stopReq && !anyActive) begin
          lpmState_nxt = pwi_pkg::LPM_STOP;
        end else if (sleepReq) begin
          lpmState_nxt = pwi_pkg::LPM_SLEEP;
        end
      end
      pwi_pkg::LPM_STOP: begin
        if (anyActive) begin
          lpmState_nxt = pwi_pkg::LPM_RUN;
        end
      end
      pwi_pkg::LPM_SLEEP: begin
        if (anyActive || sleepCnt_r == 16'h0000) begin
          lpmState_nxt = pwi_pkg::LPM_RUN;
        end
      end
    endcase
  end
  // State register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lpmState_r <= pwi_pkg::LPM_RUN;
    end else begin
      lpmState_r <= lpmState_nxt;
    end
  end
  // Timed sleep counts down from the programmed length.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleepCnt_r <= `PWI_RST_SLEEP_LEN;
    end else if (lpmState_r == pwi_pkg::LPM_RUN) begin
      sleepCnt_r <= sleepLen_r;
    end else if (lpmState_r == pwi_pkg::LPM_SLEEP &&
                 sleepCnt_r != 16'h0000) begin
      sleepCnt_r <= sleepCnt_r - 16'h0001;
    end
  end

  // On leaving a low-power mode the core either resumes at the next
  // instruction or is sent to the shared service routine first.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeResume_r <= 1'b0;
      wakeService_r <= 1'b0;
    end else begin
      wakeResume_r <= lpmState_r != pwi_pkg::LPM_RUN &&
                      lpmState_nxt == pwi_pkg::LPM_RUN &&
                      !portIrqReq;
      wakeService_r <= lpmState_r != pwi_pkg::LPM_RUN &&
                       lpmState_nxt == pwi_pkg::LPM_RUN &&
                       portIrqReq;
    end
  end
  assign coreStopped = lpmState_r == pwi_pkg::LPM_STOP;
  assign coreSleeping = lpmState_r == pwi_pkg::LPM_SLEEP;
  assign wakeResume = wakeResume_r;
  assign wakeService = wakeService_r;

  // ****************************************************************
  // Block interrupt
  // ****************************************************************
  // Sticky events; a set in the cycle of a write-one clear wins.
  always_comb begin
    intSet = 3'h0;
    intSet[`PWI_INT_WAKE] = lpmState_r != pwi_pkg::LPM_RUN && anyActive;
    intSet[`PWI_INT_REFUSED] = lpmState_r == pwi_pkg::LPM_RUN &&
                               stopReq && anyActive;
    intSet[`PWI_INT_TIMEOUT] = lpmState_r == pwi_pkg::LPM_SLEEP &&
                               !anyActive && sleepCnt_r == 16'h0000;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intStat_r <= `PWI_RST_INT;
    end else begin
      intStat_r <= (intStat_r & ~intClr) | intSet;
    end
  end
  assign irq = |(intStat_r & intMask_r);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_pend_set_edge: assert property (@(posedge core_clk)
    disable iff (!reset_n) (edgeHit != 8'h00) |=>
    ((wakePending_r & $past(edgeHit)) == $past(edgeHit)))
    else $error("Edge hit did not set its pending bit");
  chk_pend_hold: assert property (@(posedge core_clk)
    disable iff (!reset_n) 1'b1 |=> ((~wakePending_r &
    $past(wakePending_r) & ~$past(pendClr)) == 8'h00))
    else $error("Pending bit cleared without a software clear");
  chk_stop_refuse: assert property (@(posedge core_clk)
    disable iff (!reset_n) (lpmState_r == pwi_pkg::LPM_RUN && stopReq &&
    anyActive) |=> (lpmState_r == pwi_pkg::LPM_RUN &&
    intStat_r[`PWI_INT_REFUSED]))
    else $error("Stop entered while a pin was enabled and pending");
  chk_irq_gate: assert property (@(posedge core_clk)
    disable iff (!reset_n) ((edgeHit & wakeEnableMask_r) != 8'h00 &&
    portIrqGlobalEnable_r && globalIrqEnable_r) ##1 (portIrqGlobalEnable_r
    && globalIrqEnable_r) |-> portIrqReq)
    else $error("Port request missing for an enabled pending pin");
  chk_irq_needs_en: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (wakeEnableMask_r == 8'h00) |-> !portIrqReq)
    else $error("Port request raised with no pin enabled");
  chk_wake_resume: assert property (@(posedge core_clk)
    disable iff (!reset_n) (lpmState_r != pwi_pkg::LPM_RUN && anyActive &&
    !portIrqReq) |=> (wakeResume && !wakeService &&
    lpmState_r == pwi_pkg::LPM_RUN))
    else $error("Wake without interrupt did not resume");
  chk_wake_service: assert property (@(posedge core_clk)
    disable iff (!reset_n) (lpmState_r != pwi_pkg::LPM_RUN && portIrqReq)
    |=> (wakeService && !wakeResume) ##1 !wakeService)
    else $error("Wake with interrupt did not request service");
  chk_stop_hold: assert property (@(posedge core_clk)
    disable iff (!reset_n) (lpmState_r == pwi_pkg::LPM_STOP && !anyActive)
    |=> (lpmState_r == pwi_pkg::LPM_STOP))
    else $error("Stop left without an enabled pending pin");
  chk_edge_once: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (edgeHit != 8'h00) |=> ((edgeHit & $past(edgeHit)) == 8'h00))
    else $error("One pin edge counted twice");
  chk_edge_polarity: assert property (@(posedge core_clk)
    disable iff (!reset_n) (edgeHit != 8'h00) |->
    ((edgeHit & (syncC_r ^ wakeEdgeSelect_r)) == edgeHit &&
    (edgeHit & ~$past(syncC_r)) == (edgeHit & syncC_r)))
    else $error("Edge hit in the wrong direction");

endmodule

//--- bench/pwi_pin_model.sv
/*
 * Behavioural model of the signals that drive the eight port pins.
 * Assumes the bench calls put to set a new level on all pins at once.
 */
`timescale 1ns/1ps

module pwi_pin_model (
  // Clock
  input wire logic core_clk,
  // Port pins
  output logic [7:0] pinOut
);
  // ****************************************************************
  // Pin levels
  // ****************************************************************
  // Pins start low so that no edge is seen at reset release.
  initial begin
    pinOut = 8'h00;
  end

  // A level is held until the next call, well past the synchroniser.
  task automatic put(input logic [7:0] v);
    @(posedge core_clk);
    pinOut <= v;
  endtask
endmodule

//--- bench/tb_pwi_port_wakeup.sv
/*
 * Self-checking bench for the port wakeup interrupt block.
 * Assumes the design holds its own assertions and the single slave
 * loops hreadyout back to hready.
 */
`timescale 1ns/1ps
`include "pwi_regs.svh"

module tb_pwi_port_wakeup;
  logic core_clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] portPin;
  logic coreStopped, coreSleeping, wakeResume, wakeService;
  logic portIrqReq, irq, gotR, gotS;
  int n_fail, total_checks, n;

  // ****************************************************************
  // Design, pin model and clock
  // ****************************************************************
  pwi_port_wakeup dut (.core_clk(core_clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .portPin(portPin), .coreStopped(coreStopped),
    .coreSleeping(coreSleeping), .wakeResume(wakeResume),
    .wakeService(wakeService), .portIrqReq(portIrqReq), .irq(irq));
  pwi_pin_model pm (.core_clk(core_clk), .pinOut(portPin));

  // Free-running 40 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One AHB single transfer; the master never assumes a latency.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // Lets the edge's register updates land before outputs are looked at.
  task automatic settle(input int c);
    repeat (c) @(negedge core_clk);
  endtask

  // Waits a bounded time for either wake pulse and notes which came.
  task automatic waitWake();
    gotR = 1'b0;
    gotS = 1'b0;
    n = 0;
    while (!(gotR | gotS) && n < 40) begin
      @(negedge core_clk);
      gotR = wakeResume;
      gotS = wakeService;
      n++;
    end
  endtask

  // Safe edge change: disable, select edge, clear pending, enable.
  task automatic setEdge(input logic [7:0] edg, en);
    wr(`PWI_OFS_WAKE_EN, 32'h0);
    wr(`PWI_OFS_EDGE_SEL, {24'h0, edg});
    wr(`PWI_OFS_PENDING, 32'hff);
    wr(`PWI_OFS_WAKE_EN, {24'h0, en});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every register, and one unmapped word, reads zero after reset.
  task automatic tReset();
    for (int i = 0; i < 9; i++) begin
      rdChk("reset word", 8'(i * 4), 32'h0);
    end
    chk("okay resp", hresp, 1'b0);
    chk("no wait", hreadyout, 1'b1);
    wr(8'h20, 32'hffffffff);
    rdChk("unmapped", 8'h20, 32'h0);
    wr(`PWI_OFS_WAKE_EN, 32'h1ff);
    rdChk("enable width", `PWI_OFS_WAKE_EN, 32'hff);
    wr(`PWI_OFS_EDGE_SEL, 32'ha5);
    rdChk("edge rw", `PWI_OFS_EDGE_SEL, 32'ha5);
  endtask

  // Rising then falling selection; the opposite edge is ignored.
  task automatic tEdges();
    setEdge(8'h00, 8'h00);
    pm.put(8'h0f);
    settle(8);
    rdChk("rise pend", `PWI_OFS_PENDING, 32'h0f);
    setEdge(8'hff, 8'h00);
    pm.put(8'hf0);
    settle(8);
    rdChk("fall pend", `PWI_OFS_PENDING, 32'h0f);
    settle(20);
    rdChk("pend held", `PWI_OFS_PENDING, 32'h0f);
    wr(`PWI_OFS_PENDING, 32'h01);
    rdChk("pend w1c", `PWI_OFS_PENDING, 32'h0e);
  endtask

  // Shared request needs pin enable, port enable and global enable.
  task automatic tIrq();
    wr(`PWI_OFS_WAKE_EN, 32'h01);
    wr(`PWI_OFS_CTRL, 32'h3);
    settle(1);
    chk("pin masked", portIrqReq, 1'b0);
    wr(`PWI_OFS_WAKE_EN, 32'h02);
    for (int c = 0; c < 4; c++) begin
      wr(`PWI_OFS_CTRL, 32'(c));
      settle(1);
      chk("irq gate", portIrqReq, c == 3);
    end
    rdChk("status pend", `PWI_OFS_STATUS, 32'h0200);
  endtask

  // Stop is refused with an active pin; the refusal drives irq.
  task automatic tRefuse();
    wr(`PWI_OFS_CTRL, 32'h4);
    settle(2);
    chk("stop refused", coreStopped, 1'b0);
    rdChk("refuse flag", `PWI_OFS_INT_STAT, 32'h2);
    wr(`PWI_OFS_INT_MASK, 32'h0);
    settle(1);
    chk("irq masked", irq, 1'b0);
    wr(`PWI_OFS_INT_MASK, 32'h2);
    settle(1);
    chk("irq raised", irq, 1'b1);
    wr(`PWI_OFS_INT_STAT, 32'h2);
    settle(1);
    chk("irq cleared", irq, 1'b0);
  endtask

  // Stop, then wake on an enabled pin, without and with the interrupt.
  task automatic tStop(input logic [31:0] ctl, input logic svc);
    setEdge(8'h00, 8'h01);
    wr(`PWI_OFS_CTRL, ctl);
    settle(1);
    chk("stopped", coreStopped, 1'b1);
    pm.put(8'hf2);
    settle(8);
    chk("no wake", coreStopped, 1'b1);
    pm.put(8'hf3);
    waitWake();
    chk("resume", gotR, !svc);
    chk("service", gotS, svc);
    chk("awake", coreStopped, 1'b0);
    pm.put(8'hf0);
  endtask

  // Timed sleep ends after length plus one cycles.
  task automatic tSleep();
    setEdge(8'h00, 8'h01);
    wr(`PWI_OFS_INT_STAT, 32'h7);
    wr(`PWI_OFS_SLEEP_LEN, 32'h5);
    wr(`PWI_OFS_CTRL, 32'h8);
    n = 0;
    settle(1);
    while (coreSleeping === 1'b1 && n < 50) begin
      n++;
      settle(1);
    end
    chk("sleep len", 32'(n), 32'd6);
    rdChk("timeout flag", `PWI_OFS_INT_STAT, 32'h4);
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs about 300 cycles.
  initial begin
    #200000;
    n_fail++;
    conclude();
  end

  // Reset for three cycles, then every scenario in turn.
  initial begin
    n_fail = 0;
    total_checks = 0;
    reset_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    tReset();
    tEdges();
    tIrq();
    tRefuse();
    tStop(32'h4, 1'b0);
    tStop(32'h7, 1'b1);
    rdChk("wake flag", `PWI_OFS_INT_STAT, 32'h1);
    tSleep();
    conclude();
  end
endmodule
